// File: src/lut_ram_pkg.sv
// Purpose: shared constants and carriers for the look-up-table memory tile
// Assumes: 20 MHz system clock; register port of 3-bit address, 16-bit data
// Notes:   all offsets, field layouts, reset values and timing counts live here

package lut_ram_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int HOLD_LIMIT_MS = 1;
    // longest allowed post-edge phase, rounded down to whole cycles
    localparam int HOLD_LIMIT_CYCLES = (HOLD_LIMIT_MS * 1000000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int TABLE_DEPTH = 16;
    localparam int TABLE_AW = 4;
    localparam int REG_AW = 3;
    localparam int REG_DW = 16;
    localparam int H_TABLE_W = 8;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [REG_AW-1:0] REG_CFG = 3'h0;
    localparam logic [REG_AW-1:0] REG_H_TABLE = 3'h1;
    localparam logic [REG_AW-1:0] REG_G_TABLE = 3'h2;
    localparam logic [REG_AW-1:0] REG_STATUS = 3'h3;
    localparam logic [REG_AW-1:0] REG_ACTION = 3'h4;

    // action register bit positions (write only, self clearing)
    localparam int ACT_LOAD_BIT = 0;
    localparam int ACT_CLR_HOLD_BIT = 1;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_16X2 = 2'h0,
        MODE_32X1 = 2'h1,
        MODE_DUAL = 2'h2,
        MODE_F_RAM_G_LOGIC = 2'h3
    } mode_type;

    typedef enum logic [1:0] {
        FF_SRC_F = 2'h0,
        FF_SRC_G = 2'h1,
        FF_SRC_H = 2'h2,
        FF_SRC_D0 = 2'h3
    } ff_src_type;

    // ------------------------------------------------------------------
    // configuration register layout, bit 0 upward from the bottom field
    // ------------------------------------------------------------------
    typedef struct packed {
        ff_src_type yq_src;     // bits 11:10
        ff_src_type xq_src;     // bits 9:8
        logic y_sel_h;          // bit 7
        logic x_sel_h;          // bit 6
        logic share_addr;       // bit 5
        logic ff_falling;       // bit 4
        logic wclk_falling;     // bit 3
        logic level_mode;       // bit 2
        mode_type mode;         // bits 1:0
    } cfg_type;

    localparam int CFG_W = 12;
    localparam cfg_type CFG_RESET = cfg_type'(12'h000);
    localparam logic [H_TABLE_W-1:0] H_TABLE_RESET = 8'h00;
    localparam logic [TABLE_DEPTH-1:0] G_TABLE_RESET = 16'h0000;
    localparam logic [TABLE_DEPTH-1:0] INIT_DEFAULT = 16'h0000;

    // status register layout
    typedef struct packed {
        logic hold_flag;        // bit 7
        logic yq;               // bit 6
        logic xq;               // bit 5
        logic y;                // bit 4
        logic x;                // bit 3
        logic h;                // bit 2
        logic g;                // bit 1
        logic f;                // bit 0
    } status_type;

    localparam int STATUS_W = 8;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [TABLE_AW-1:0] first_table_address;
        logic [TABLE_AW-1:0] second_table_address;
        logic data_in_first;
        logic data_in_second_or_addr_msb;
        logic write_enable;
    } ram_in_type;

    typedef struct packed {
        logic [REG_AW-1:0] addr;
        logic [REG_DW-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

endpackage

// File: src/lut_distributed_ram.sv
// Purpose: one logic tile's pair of look-up tables used as read/write memory
// Assumes: user logic on clk drives ram_in; tile_clk arrives as a pin
// Notes:   reads are combinational; contents survive arst_n

`timescale 1ns/100ps

module lut_distributed_ram #(
    parameter logic [15:0] INIT_FIRST = lut_ram_pkg::INIT_DEFAULT,
    parameter logic [15:0] INIT_SECOND = lut_ram_pkg::INIT_DEFAULT,
    parameter int HOLD_LIMIT = lut_ram_pkg::HOLD_LIMIT_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire lut_ram_pkg::ram_in_type ram_in,
    input wire logic tile_clk,
    input wire lut_ram_pkg::reg_req_type reg_req,
    output logic [lut_ram_pkg::REG_DW-1:0] reg_rdata,
    output logic single_port_out,
    output logic dual_port_out,
    output logic xq_out,
    output logic yq_out
);
    import lut_ram_pkg::*;

    localparam int HOLD_CW = $clog2(HOLD_LIMIT + 1);
    localparam logic [HOLD_CW-1:0] HOLD_LIMIT_C = HOLD_CW'(HOLD_LIMIT);
    localparam logic [HOLD_CW-1:0] HOLD_ONE = HOLD_CW'(1);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sync;                 // tile clock synchroniser
        logic clk_level;                  // filtered tile clock
        cfg_type cfg;
        logic [H_TABLE_W-1:0] h_table;
        logic [TABLE_DEPTH-1:0] g_table;
        ram_in_type cap;                  // inputs caught at the write edge
        logic cap_valid;                  // internal write pulse pending
        logic load;                       // reload initial contents
        logic hold_armed;
        logic [HOLD_CW-1:0] hold_cnt;
        logic hold_flag;
        logic xq;
        logic yq;
        logic [REG_DW-1:0] rdata;
    } state_type;

    localparam state_type STATE_RESET = '{
        sync: 3'h0,
        clk_level: 1'b0,
        cfg: CFG_RESET,
        h_table: H_TABLE_RESET,
        g_table: G_TABLE_RESET,
        cap: '0,
        cap_valid: 1'b0,
        load: 1'b0,
        hold_armed: 1'b0,
        hold_cnt: '0,
        hold_flag: 1'b0,
        xq: 1'b0,
        yq: 1'b0,
        rdata: 16'h0000
    };

    state_type s_q;
    state_type s_d;

    // memory cells are kept apart from the reset state so arst_n leaves them alone
    // cells start from the configuration image; only the load action
    // brings that image back while the tile runs
    logic [TABLE_DEPTH-1:0] mem_f_q = INIT_FIRST;
    logic [TABLE_DEPTH-1:0] mem_g_q = INIT_SECOND;
    logic [TABLE_DEPTH-1:0] mem_f_d;
    logic [TABLE_DEPTH-1:0] mem_g_d;

    // combinational read paths
    logic f_out;
    logic g_out;
    logic h_out;
    logic x_out;
    logic y_out;

    // ------------------------------------------------------------------
    // flip-flop source select
    // ------------------------------------------------------------------
    function automatic logic ff_pick(input ff_src_type src, input logic f, input logic g,
                                     input logic h, input logic d0);
        logic r;
        r = f;
        case (src)
            FF_SRC_F: r = f;
            FF_SRC_G: r = g;
            FF_SRC_H: r = h;
            FF_SRC_D0: r = d0;
            default: r = f;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // pure muxes of the cells on live addresses, so no clock is waited on
    // 32x1 reads both tables on one address and lets msb choose
    always_comb begin
        logic [TABLE_AW-1:0] a_first;
        logic [TABLE_AW-1:0] a_second;
        logic msb;
        a_first = ram_in.first_table_address;
        a_second = ram_in.second_table_address;
        msb = ram_in.data_in_second_or_addr_msb;
        f_out = mem_f_q[a_first];
        g_out = mem_g_q[a_second];
        case (s_q.cfg.mode)
            MODE_16X2: begin
                // second table may follow the first address
                g_out = s_q.cfg.share_addr ? mem_g_q[a_first] : mem_g_q[a_second];
            end
            MODE_32X1: begin
                // both tables see the same address; msb picks the table
                f_out = msb ? mem_g_q[a_first] : mem_f_q[a_first];
                g_out = mem_g_q[a_first];
            end
            MODE_DUAL: begin
                // second read port has its own address
                g_out = mem_g_q[a_second];
            end
            MODE_F_RAM_G_LOGIC: begin
                // second table is a plain four-input function
                g_out = s_q.g_table[a_second];
            end
            default: begin
                g_out = mem_g_q[a_second];
            end
        endcase
        // third table: function of both outputs and the second data input
        h_out = s_q.h_table[{msb, g_out, f_out}];
        x_out = s_q.cfg.x_sel_h ? h_out : f_out;
        y_out = s_q.cfg.y_sel_h ? h_out : g_out;
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic rise;
        logic fall;
        logic wr_edge;
        logic ff_edge;
        logic level;
        logic post_level;
        logic wr_go;
        ram_in_type src;
        logic [TABLE_AW-1:0] g_waddr;
        status_type st;
        // defaults first, so no path leaves a local without a value
        rise = 1'b0;
        fall = 1'b0;
        wr_edge = 1'b0;
        ff_edge = 1'b0;
        level = 1'b0;
        post_level = 1'b0;
        wr_go = 1'b0;
        src = '0;
        g_waddr = '0;
        st = '0;

        s_d = s_q;
        mem_f_d = mem_f_q;
        mem_g_d = mem_g_q;

        // three-stage synchroniser; the first stage feeds only the second
        // a pin change shows on the fourth clk; pulses seen by only one clk edge are lost
        s_d.sync = {s_q.sync[1:0], tile_clk};
        if (s_q.sync[1] == s_q.sync[2]) begin
            s_d.clk_level = s_q.sync[2];
        end
        rise = s_d.clk_level & ~s_q.clk_level;
        fall = ~s_d.clk_level & s_q.clk_level;

        // write and flip-flop edges are inverted independently
        wr_edge = s_q.cfg.wclk_falling ? fall : rise;
        ff_edge = s_q.cfg.ff_falling ? fall : rise;

        // dual-port always writes on the edge; one mode covers both tables
        // level mode trades the edge capture for latch-like writes that
        // follow every change of data while the enable is high
        level = s_q.cfg.level_mode && (s_q.cfg.mode != MODE_DUAL);

        // edge mode: catch address, data and enable together at the edge
        // the edge is seen 3 clk late, so ram_in must hold around it
        s_d.cap_valid = 1'b0;
        if (wr_edge && !level) begin
            s_d.cap = ram_in;
            s_d.cap_valid = ram_in.write_enable;
        end

        // the caught inputs write one cycle later, independent of live pins
        if (level) begin
            src = ram_in;
            wr_go = ram_in.write_enable;
        end else begin
            src = s_q.cap;
            wr_go = s_q.cap_valid;
        end

        g_waddr = s_q.cfg.share_addr ? src.first_table_address : src.second_table_address;

        if (wr_go) begin
            case (s_q.cfg.mode)
                MODE_16X2: begin
                    // two independent arrays, each with its own data input
                    mem_f_d[src.first_table_address] = src.data_in_first;
                    mem_g_d[g_waddr] = src.data_in_second_or_addr_msb;
                end
                MODE_32X1: begin
                    if (src.data_in_second_or_addr_msb) begin
                        mem_g_d[src.first_table_address] = src.data_in_first;
                    end else begin
                        mem_f_d[src.first_table_address] = src.data_in_first;
                    end
                end
                MODE_DUAL: begin
                    // first address is the write address of both tables
                    mem_f_d[src.first_table_address] = src.data_in_first;
                    mem_g_d[src.first_table_address] = src.data_in_first;
                end
                MODE_F_RAM_G_LOGIC: begin
                    mem_f_d[src.first_table_address] = src.data_in_first;
                end
                default: begin
                    mem_f_d = mem_f_q;
                end
            endcase
        end

        // configuration reload wins over any write in the same cycle
        if (s_q.load) begin
            mem_f_d = INIT_FIRST;
            mem_g_d = INIT_SECOND;
        end
        s_d.load = 1'b0;

        // tile flip-flops hold either output, the third table or data
        // their edge is decoded apart from the write edge, so results can
        // be registered on either edge of the tile clock
        if (ff_edge) begin
            s_d.xq = ff_pick(s_q.cfg.xq_src, f_out, g_out, h_out,
                             ram_in.data_in_first);
            s_d.yq = ff_pick(s_q.cfg.yq_src, f_out, g_out, h_out,
                             ram_in.data_in_first);
        end

        // watch for the write clock parked after its active edge; a stop
        // there is harmful, so software gets a sticky flag to find it
        // the counter saturates at the limit, so the flag is set again each
        // cycle and a clear does not hold while the clock stays parked
        post_level = ~s_q.cfg.wclk_falling;
        if (level) begin
            s_d.hold_armed = 1'b0;
            s_d.hold_cnt = '0;
        end else if (wr_edge) begin
            s_d.hold_armed = 1'b1;
            s_d.hold_cnt = '0;
        end else if (s_q.hold_armed && (s_q.clk_level == post_level)) begin
            if (s_q.hold_cnt != HOLD_LIMIT_C) begin
                s_d.hold_cnt = s_q.hold_cnt + HOLD_ONE;
            end
        end else begin
            s_d.hold_armed = 1'b0;
            s_d.hold_cnt = '0;
        end

        // register writes
        // action bits are pulses: load lasts one cycle, the clear acts once
        if (reg_req.wr) begin
            case (reg_req.addr)
                REG_CFG: s_d.cfg = cfg_type'(reg_req.wdata[CFG_W-1:0]);
                REG_H_TABLE: s_d.h_table = reg_req.wdata[H_TABLE_W-1:0];
                REG_G_TABLE: s_d.g_table = reg_req.wdata[TABLE_DEPTH-1:0];
                REG_ACTION: begin
                    s_d.load = reg_req.wdata[ACT_LOAD_BIT];
                    if (reg_req.wdata[ACT_CLR_HOLD_BIT]) begin
                        s_d.hold_flag = 1'b0;
                    end
                end
                default: s_d.load = 1'b0;
            endcase
        end

        // set after clear, so an event in the clearing cycle is kept
        if (s_q.hold_armed && (s_q.hold_cnt == HOLD_LIMIT_C)) begin
            s_d.hold_flag = 1'b1;
        end

        // read data stand only in the cycle after the strobe
        // a status read shows the live table outputs of the strobe cycle
        st = '{hold_flag: s_q.hold_flag, yq: s_q.yq, xq: s_q.xq, y: y_out,
               x: x_out, h: h_out, g: g_out, f: f_out};
        s_d.rdata = 16'h0000;
        if (reg_req.rd) begin
            case (reg_req.addr)
                REG_CFG: s_d.rdata = {4'h0, s_q.cfg};
                REG_H_TABLE: s_d.rdata = {8'h00, s_q.h_table};
                REG_G_TABLE: s_d.rdata = s_q.g_table;
                REG_STATUS: s_d.rdata = {8'h00, st};
                default: s_d.rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // control state: async reset to constants
    // contents stay in the cells below, which have no reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // memory cells: no reset on purpose
    always_ff @(posedge clk) begin
        mem_f_q <= mem_f_d;
        mem_g_q <= mem_g_d;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // table outputs stay combinational so a read never waits for a clock
    // flip-flop outputs and read data are registered; only the table
    // outputs bypass the registers, by intent
    assign single_port_out = x_out;
    assign dual_port_out = y_out;
    assign xq_out = s_q.xq;
    assign yq_out = s_q.yq;
    assign reg_rdata = s_q.rdata;

endmodule

// File: tb/lut_ram_chk.sv
// Purpose: port-level checks for the tile memory and its register port
// Assumes: single clk domain, arst_n asynchronous active low
// Notes: shadows of written registers kept here to judge read-back
`timescale 1ns/100ps

module lut_ram_chk
    import lut_ram_pkg::*;
#(
    parameter int HOLD_LIMIT = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire lut_ram_pkg::ram_in_type ram_in,
    input wire logic tile_clk,
    input wire lut_ram_pkg::reg_req_type reg_req,
    input wire logic [lut_ram_pkg::REG_DW-1:0] reg_rdata,
    input wire logic single_port_out,
    input wire logic dual_port_out,
    input wire logic xq_out,
    input wire logic yq_out
);
    logic [11:0] cfg_q;
    logic [7:0] h_q;
    logic [15:0] g_q;

    // shadow copies of the writable registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= 12'h000;
            h_q <= 8'h00;
            g_q <= 16'h0000;
        end else if (reg_req.wr) begin
            if (reg_req.addr == REG_CFG) cfg_q <= reg_req.wdata[11:0];
            if (reg_req.addr == REG_H_TABLE) h_q <= reg_req.wdata[7:0];
            if (reg_req.addr == REG_G_TABLE) g_q <= reg_req.wdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // long enough for a pending tile edge to finish its write
    sequence quiet_s;
        (!reg_req.wr && $stable(ram_in) && $stable(tile_clk)) [*8];
    endsequence
    sequence pin_still_s;
        $stable(tile_clk) [*6];
    endsequence

    a_rdata_idle_zero: assert property (!reg_req.rd |=> reg_rdata == 16'h0000)
        else $error("read data present without a read");
    a_unmapped_zero: assert property (reg_req.rd && reg_req.addr > REG_ACTION
        |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_action_reads_zero: assert property (reg_req.rd && reg_req.addr == REG_ACTION
        |=> reg_rdata == 16'h0000) else $error("action register read not zero");
    a_cfg_read_back: assert property (reg_req.rd && reg_req.addr == REG_CFG
        |=> reg_rdata == {4'h0, cfg_q}) else $error("config read back wrong");
    a_htab_read_back: assert property (reg_req.rd && reg_req.addr == REG_H_TABLE
        |=> reg_rdata == {8'h00, h_q}) else $error("third table read back wrong");
    a_gtab_read_back: assert property (reg_req.rd && reg_req.addr == REG_G_TABLE
        |=> reg_rdata == g_q) else $error("logic table read back wrong");
    a_status_outs: assert property (reg_req.rd && reg_req.addr == REG_STATUS
        && $stable(single_port_out) && $stable(dual_port_out)
        |=> reg_rdata[3] == $past(single_port_out) && reg_rdata[4] == $past(dual_port_out)
        && reg_rdata[15:8] == 8'h00) else $error("status does not mirror outputs");
    a_quiet_outs: assert property (quiet_s
        |-> $stable(single_port_out) && $stable(dual_port_out))
        else $error("memory output moved without a cause");
    a_ff_quiet: assert property (pin_still_s |-> $stable(xq_out) && $stable(yq_out))
        else $error("tile flip-flop moved without a tile clock edge");
endmodule

bind lut_distributed_ram lut_ram_chk #(.HOLD_LIMIT(HOLD_LIMIT)) chk (.clk(clk),
    .arst_n(arst_n), .ram_in(ram_in), .tile_clk(tile_clk), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .single_port_out(single_port_out),
    .dual_port_out(dual_port_out), .xq_out(xq_out), .yq_out(yq_out));

// File: tb/tile_user_model.sv
// Purpose: user logic that feeds address, data, enable and the tile clock
// Assumes: changes land by non-blocking assignment after a clk edge
// Notes: each tile clock phase lasts at least 7 clk, far beyond the filter
`timescale 1ns/100ps

module tile_user_model
    import lut_ram_pkg::*;
(
    input wire logic clk,
    output lut_ram_pkg::ram_in_type ram_in,
    output logic tile_clk
);
    // quiet inputs from time zero
    initial begin
        ram_in = '0;
        tile_clk = 1'b0;
    end

    // address and data settle two edges before anything samples them
    task automatic present(input logic [3:0] a1, a2, input logic d0, d1, we);
        @(posedge clk);
        ram_in <= '{a1, a2, d0, d1, we};
        repeat (2) @(posedge clk);
    endtask

    // one tile clock phase; short phases keep the post-edge pulse brief
    task automatic half(input logic we);
        @(posedge clk);
        ram_in.write_enable <= we;
        tile_clk <= ~tile_clk;
        repeat (6) @(posedge clk);
    endtask

    // full period, enable chosen per phase
    task automatic tick(input logic we_a, we_b);
        half(we_a);
        half(we_b);
    endtask
endmodule

// File: tb/lut_distributed_ram_tb.sv
// Purpose: directed checks of tile memory modes and register port
// Assumes: HOLD_LIMIT shortened to 16 cycles
// Notes: contents preloaded with nonzero patterns to see the initial image and retention
`timescale 1ns/100ps

module lut_distributed_ram_tb;
    import lut_ram_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    ram_in_type ram_in;
    logic tile_clk;
    reg_req_type reg_req = '0;
    logic [15:0] reg_rdata;
    logic single_port_out, dual_port_out, xq_out, yq_out;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;

    lut_distributed_ram #(.INIT_FIRST(16'h0081), .INIT_SECOND(16'h0002), .HOLD_LIMIT(16)) dut (
        .clk(clk), .arst_n(arst_n), .ram_in(ram_in), .tile_clk(tile_clk), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .single_port_out(single_port_out),
        .dual_port_out(dual_port_out), .xq_out(xq_out), .yq_out(yq_out));
    tile_user_model m (.clk(clk), .ram_in(ram_in), .tile_clk(tile_clk));

    always #25 clk = ~clk;

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic compare(input logic [15:0] got, exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // an idle cycle between strobes keeps each signal at one driver per step
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] mask, exp);
        @(posedge clk);
        reg_req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        #1 compare(reg_rdata & mask, exp);
    endtask

    // set read addresses with enable low, then check both outputs
    task automatic look(input logic [3:0] a1, a2, input logic msb, es, ed);
        m.present(a1, a2, 1'b0, msb, 1'b0);
        #1 compare({14'h0, dual_port_out, single_port_out}, {14'h0, ed, es});
    endtask

    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        look(4'h0, 4'h1, 1'b0, 1'b1, 1'b1);
        look(4'h7, 4'h2, 1'b0, 1'b1, 1'b0);
        wr(3'h0, 16'hFFFF);
        rd(3'h0, 16'hFFFF, 16'h0FFF);
        wr(3'h0, 16'h0000);
        wr(3'h6, 16'hFFFF);
        rd(3'h6, 16'hFFFF, 16'h0000);
        rd(3'h4, 16'hFFFF, 16'h0000);
        wr(3'h1, 16'hFFA5);
        rd(3'h1, 16'hFFFF, 16'h00A5);
        wr(3'h2, 16'h1234);
        rd(3'h2, 16'hFFFF, 16'h1234);
        rd(3'h3, 16'hFF00, 16'h0000);
        // two arrays, edge timing
        m.present(4'h4, 4'h4, 1'b1, 1'b1, 1'b1);
        look(4'h4, 4'h4, 1'b0, 1'b0, 1'b0);
        m.present(4'h3, 4'h5, 1'b1, 1'b1, 1'b0);
        m.tick(1'b0, 1'b0);
        look(4'h3, 4'h5, 1'b0, 1'b0, 1'b0);
        m.present(4'h3, 4'h5, 1'b1, 1'b1, 1'b0);
        m.tick(1'b1, 1'b0);
        look(4'h3, 4'h5, 1'b1, 1'b1, 1'b1);
        m.tick(1'b0, 1'b0);
        #1 compare({14'h0, xq_out, yq_out}, 16'h0003);
        // single 32-word array
        wr(3'h0, 16'h0001);
        m.present(4'h2, 4'h2, 1'b1, 1'b1, 1'b0);
        m.tick(1'b1, 1'b0);
        look(4'h2, 4'h2, 1'b1, 1'b1, 1'b1);
        look(4'h2, 4'h2, 1'b0, 1'b0, 1'b1);
        // dual port
        wr(3'h0, 16'h0002);
        m.present(4'h6, 4'h6, 1'b1, 1'b0, 1'b0);
        m.tick(1'b1, 1'b0);
        look(4'h6, 4'h6, 1'b0, 1'b1, 1'b1);
        look(4'h6, 4'h3, 1'b0, 1'b1, 1'b0);
        // level timing, data change while enabled
        wr(3'h0, 16'h0004);
        m.present(4'h9, 4'hA, 1'b1, 1'b1, 1'b1);
        #1 compare({15'h0, single_port_out}, 16'h0001);
        m.present(4'h9, 4'hA, 1'b0, 1'b1, 1'b1);
        look(4'h9, 4'hA, 1'b1, 1'b0, 1'b1);
        // falling write edge
        wr(3'h0, 16'h0008);
        m.present(4'hB, 4'hB, 1'b1, 1'b1, 1'b0);
        m.half(1'b1);
        #1 compare({15'h0, single_port_out}, 16'h0000);
        m.half(1'b1);
        look(4'hB, 4'hB, 1'b1, 1'b1, 1'b1);
        m.half(1'b0);
        wr(3'h0, 16'h0000);
        m.half(1'b0);
        // clock stopped after its active edge
        wr(3'h4, 16'h0002);
        rd(3'h3, 16'h0080, 16'h0000);
        m.half(1'b0);
        repeat (30) @(posedge clk);
        rd(3'h3, 16'h0080, 16'h0080);
        m.half(1'b0);
        wr(3'h4, 16'h0002);
        rd(3'h3, 16'h0080, 16'h0000);
        // shared address, then the third table on both outputs
        wr(3'h0, 16'h0020);
        m.present(4'hC, 4'h0, 1'b1, 1'b1, 1'b0);
        m.tick(1'b1, 1'b0);
        look(4'hC, 4'h0, 1'b0, 1'b1, 1'b1);
        wr(3'h0, 16'h00C0);
        look(4'hC, 4'hC, 1'b0, 1'b0, 1'b0);
        look(4'hC, 4'hC, 1'b1, 1'b1, 1'b1);
        // flip-flops on the falling edge, fed from second table and data
        wr(3'h0, 16'h0D10);
        m.present(4'h2, 4'hC, 1'b1, 1'b0, 1'b0);
        m.half(1'b0);
        m.present(4'h2, 4'hC, 1'b0, 1'b0, 1'b0);
        m.half(1'b0);
        #1 compare({14'h0, xq_out, yq_out}, 16'h0002);
        // first table as memory, second as a plain function
        wr(3'h0, 16'h0003);
        look(4'h0, 4'h4, 1'b0, 1'b1, 1'b1);
        look(4'h0, 4'h1, 1'b0, 1'b1, 1'b0);
        // reset in mid-run leaves contents alone
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        look(4'h3, 4'h5, 1'b0, 1'b1, 1'b1);
        rd(3'h0, 16'hFFFF, 16'h0000);
        final_report();
    end
endmodule
